// [srct_top.sv]
// Serial receive completion tracker: Avalon-MM registers, read engine, events
// Operation
// - Error when port not in framing-free mode
// - Error on bad control word, else cleared
// - Error when byte count above 0100 hex
// - Read copies up to requested bytes
// - Count mode: done at configured count
// - Terminator mode: done at end or 256
// - Count mode: byte after done sets overflow
// - Terminator mode: late or 257th byte overflows
// - Per-port byte counter, 0 to 256, up to 257 in CR+LF end mode
// - Primary done bit 6, overflow bit 7
// - Add-on done bit 14, overflow bit 15
// - Add-on counter is 9 bits, read in a 16-bit word
// - Read clears done and counter
// - Restart clears done and counter
// - Zero-length read clears both flags, stores nothing
// - Start and end markers not counted
`timescale 1ns/1ps
`default_nettype none
`include "srct_defs.svh"

module srct_top (
  input  wire logic                      sys_clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [11:0]               avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output logic [31:0]                    avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire srct_pkg::srct_rx_byte_type primary_rx_i,
  input  wire srct_pkg::srct_rx_byte_type addon_rx_i,
  output logic                           irq_o
);
  import srct_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    integer      i;
    r = old_v;
    for (i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0]        pri_cfg;
  logic [31:0]        add_cfg;
  logic [15:0]        nbytes;
  logic [4:0]         mask;
  logic [4:0]         ev;
  logic [4:0]         next_ev;
  logic               err_flag;
  logic [8:0]         last_len;
  srct_cmd_state_type state;
  logic               sel_add;
  logic [8:0]         len;
  logic [8:0]         idx;
  logic               cp_v;
  logic [7:0]         cp_idx;
  logic               rd_ready;
  logic [31:0]        rd_mux;
  logic [1:0]         done_q;
  logic [1:0]         ovf_q;
  logic [7:0]         dest_mem [0:255];

  srct_port_cfg_type  cfg_arr [2];
  srct_rx_byte_type   rx_arr [2];
  logic [7:0]         rd_data [2];
  logic [8:0]         cnt [2];
  logic [1:0]         done;
  logic [1:0]         ovf;
  logic [1:0]         read_clear;
  logic [1:0]         zero_clear;
  logic [1:0]         restart;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire cmd_wr  = avs_write_i & hit(avs_address_i, `SRCT_OFS_CMD);
  wire wr_acc  = avs_write_i & ~avs_waitrequest_o;
  wire rd_acc  = avs_read_i & rd_ready;
  wire rd_load = avs_read_i & ~rd_ready;
  wire dest_hit = avs_address_i[11:10] == `SRCT_DEST_WIN;

  // Reads take one wait state; a receive read holds the bus until the copy ends
  assign avs_waitrequest_o = rd_load | (cmd_wr & (state != CMD_DONE));

  // ----------------------------------------
  // Request check
  // ----------------------------------------
  srct_ctrl_type req_c;
  assign req_c = srct_ctrl_type'(avs_writedata_i[15:0]);

  wire req_pri  = req_c.port == `SRCT_PORT_PRI;
  wire req_add  = req_c.port == `SRCT_PORT_ADD;
  wire ctrl_bad = ~(req_pri | req_add) | (req_c.monitor > `SRCT_MON_MAX)
                | (req_c.order > `SRCT_ORDER_MAX) | (req_c.rsvd != 4'h0);
  wire mode_bad = req_add ? ~add_cfg[0] : ~pri_cfg[0];
  wire n_bad    = nbytes > `SRCT_N_MAX;
  wire req_err  = ctrl_bad | mode_bad | n_bad;
  wire err_set  = (state == CMD_IDLE) & cmd_wr & req_err;

  wire [8:0] have    = req_add ? cnt[1] : cnt[0];
  wire [8:0] n9      = nbytes[8:0];
  wire [8:0] req_len = (req_c.monitor != 4'h0) ? 9'h000 : ((n9 < have) ? n9 : have);

  wire fin      = (state == CMD_DONE) & cmd_wr & ~err_flag;
  wire zero_req = nbytes == 16'h0000;
  wire rst_wr   = wr_acc & hit(avs_address_i, `SRCT_OFS_RESTART) & avs_byteenable_i[0];

  // ----------------------------------------
  // Ports
  // ----------------------------------------
  assign cfg_arr[0] = srct_port_cfg_type'(pri_cfg);
  assign cfg_arr[1] = srct_port_cfg_type'(add_cfg);
  assign rx_arr[0]  = primary_rx_i;
  assign rx_arr[1]  = addon_rx_i;

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      assign read_clear[p] = fin & ~zero_req & (sel_add == (p == 1));
      assign zero_clear[p] = fin & zero_req & (sel_add == (p == 1));
      assign restart[p]    = rst_wr & avs_writedata_i[p];

      srct_port_tracker u_trk (
        .sys_clk_i    (sys_clk_i),
        .reset_n_i    (reset_n_i),
        .cfg_i        (cfg_arr[p]),
        .rx_i         (rx_arr[p]),
        .read_clear_i (read_clear[p]),
        .zero_clear_i (zero_clear[p]),
        .restart_i    (restart[p]),
        .rd_addr_i    (idx[7:0]),
        .rd_data_o    (rd_data[p]),
        .count_o      (cnt[p]),
        .done_o       (done[p]),
        .overflow_o   (ovf[p])
      );
    end
  endgenerate

  // ----------------------------------------
  // Receive read engine
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= CMD_IDLE;
      err_flag <= 1'b0;
      sel_add  <= 1'b0;
      len      <= 9'h000;
      idx      <= 9'h000;
      last_len <= 9'h000;
    end else begin
      case (state)
        CMD_IDLE: begin
          if (cmd_wr) begin
            err_flag <= req_err;
            sel_add  <= req_add;
            len      <= req_err ? 9'h000 : req_len;
            idx      <= 9'h000;
            state    <= req_err ? CMD_DONE : CMD_COPY;
          end
        end
        CMD_COPY: begin
          if (idx < len) begin
            idx <= idx + 9'h001;
          end else if (!cp_v) begin
            state <= CMD_DONE;
          end
        end
        CMD_DONE: begin
          if (wr_acc & cmd_wr) begin
            last_len <= len;
            state    <= CMD_IDLE;
          end
        end
        default: begin
          state <= CMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cp_v   <= 1'b0;
      cp_idx <= 8'h00;
    end else begin
      cp_v   <= (state == CMD_COPY) & (idx < len);
      cp_idx <= idx[7:0];
    end
  end

  // Destination storage, filled in order from offset zero
  always_ff @(posedge sys_clk_i) begin
    if (cp_v) begin
      dest_mem[cp_idx] <= sel_add ? rd_data[1] : rd_data[0];
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  wire [31:0] nbytes_merge = be_merge({16'h0000, nbytes}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] mask_merge   = be_merge({27'h0, mask}, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pri_cfg <= `SRCT_CFG_RST;
      add_cfg <= `SRCT_CFG_RST;
      nbytes  <= `SRCT_NBYTES_RST;
      mask    <= `SRCT_MASK_RST;
    end else if (wr_acc) begin
      if (hit(avs_address_i, `SRCT_OFS_PRI_CFG)) begin
        pri_cfg <= be_merge(pri_cfg, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, `SRCT_OFS_ADD_CFG)) begin
        add_cfg <= be_merge(add_cfg, avs_writedata_i, avs_byteenable_i);
      end else if (hit(avs_address_i, `SRCT_OFS_NBYTES)) begin
        nbytes <= nbytes_merge[15:0];
      end else if (hit(avs_address_i, `SRCT_OFS_MASK)) begin
        mask <= mask_merge[4:0];
      end
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  wire [4:0] ev_set = {err_set,
                       ovf[1] & ~ovf_q[1], done[1] & ~done_q[1],
                       ovf[0] & ~ovf_q[0], done[0] & ~done_q[0]};
  wire       ev_rd  = rd_acc & hit(avs_address_i, `SRCT_OFS_EVENT);

  // A read clears only the bits it returned, so an event landing meanwhile survives
  always_comb begin
    next_ev = (ev_rd ? (ev & ~avs_readdata_o[4:0]) : ev) | ev_set;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev     <= 5'h00;
      done_q <= 2'b00;
      ovf_q  <= 2'b00;
    end else begin
      ev     <= next_ev;
      done_q <= done;
      ovf_q  <= ovf;
    end
  end

  assign irq_o = |(ev & mask);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address_i, `SRCT_OFS_STATUS)) begin
      rd_mux[`SRCT_BIT_PRI_DONE] = done[0];
      rd_mux[`SRCT_BIT_PRI_OVF]  = ovf[0];
      rd_mux[`SRCT_BIT_ADD_DONE] = done[1];
      rd_mux[`SRCT_BIT_ADD_OVF]  = ovf[1];
    end else if (hit(avs_address_i, `SRCT_OFS_PRI_CNT)) begin
      rd_mux = {23'h0, cnt[0]};
    end else if (hit(avs_address_i, `SRCT_OFS_ADD_CNT)) begin
      rd_mux = {16'h0000, 7'h00, cnt[1]};
    end else if (hit(avs_address_i, `SRCT_OFS_PRI_CFG)) begin
      rd_mux = pri_cfg;
    end else if (hit(avs_address_i, `SRCT_OFS_ADD_CFG)) begin
      rd_mux = add_cfg;
    end else if (hit(avs_address_i, `SRCT_OFS_NBYTES)) begin
      rd_mux = {16'h0000, nbytes};
    end else if (hit(avs_address_i, `SRCT_OFS_RESULT)) begin
      rd_mux = {7'h00, last_len, 15'h0000, err_flag};
    end else if (hit(avs_address_i, `SRCT_OFS_EVENT)) begin
      rd_mux = {27'h0, ev};
    end else if (hit(avs_address_i, `SRCT_OFS_MASK)) begin
      rd_mux = {27'h0, mask};
    end else if (dest_hit) begin
      rd_mux = {24'h0, dest_mem[avs_address_i[9:2]]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ready       <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      rd_ready <= rd_load;
      if (rd_load) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_err_nrange: assert property (state == CMD_IDLE && cmd_wr && nbytes > 16'h0100 |=> err_flag)
    else $error("oversize byte count not flagged");
  chk_err_mode: assert property (state == CMD_IDLE && cmd_wr && mode_bad |=> err_flag)
    else $error("port mode error not flagged");
  chk_err_ctrl: assert property (state == CMD_IDLE && cmd_wr && req_c.port == 4'h0
                                 |=> err_flag ##1 state != CMD_COPY)
    else $error("bad control word not flagged");
  chk_err_clear: assert property (state == CMD_IDLE && cmd_wr && !req_err |=> !err_flag)
    else $error("error flag not cleared");
  chk_copy_bound: assert property (state == CMD_COPY |-> idx <= len && len <= 9'h100)
    else $error("copy ran past the request");
  chk_read_clears: assert property (read_clear[0] && !restart[0] && !primary_rx_i.valid
                                    |=> !done[0] && cnt[0] == 9'h000)
    else $error("read did not clear primary port");
  chk_status_pri: assert property (rd_load && hit(avs_address_i, `SRCT_OFS_STATUS)
                                   |=> avs_readdata_o[7:6] == $past({ovf[0], done[0]}))
    else $error("primary flags misplaced");
  chk_status_add: assert property (rd_load && hit(avs_address_i, `SRCT_OFS_STATUS)
                                   |=> avs_readdata_o[15:14] == $past({ovf[1], done[1]}))
    else $error("add-on flags misplaced");
  chk_addon_word: assert property (rd_load && hit(avs_address_i, `SRCT_OFS_ADD_CNT)
                                   |=> avs_readdata_o[15:0] == {7'h00, $past(cnt[1])})
    else $error("add-on counter word wrong");
  cov_copy: cover property (state == CMD_COPY ##[1:300] state == CMD_DONE);
  cov_err: cover property (err_set);
  cov_irq: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// [srct_defs.svh]
// Register offsets, field positions, reset values and limits
`ifndef SRCT_DEFS_SVH
`define SRCT_DEFS_SVH

`define SRCT_OFS_STATUS   12'h000
`define SRCT_OFS_PRI_CNT  12'h004
`define SRCT_OFS_ADD_CNT  12'h008
`define SRCT_OFS_PRI_CFG  12'h00c
`define SRCT_OFS_ADD_CFG  12'h010
`define SRCT_OFS_CMD      12'h014
`define SRCT_OFS_NBYTES   12'h018
`define SRCT_OFS_RESULT   12'h01c
`define SRCT_OFS_EVENT    12'h020
`define SRCT_OFS_MASK     12'h024
`define SRCT_OFS_RESTART  12'h028
`define SRCT_DEST_WIN     2'h1

`define SRCT_BIT_PRI_DONE 6
`define SRCT_BIT_PRI_OVF  7
`define SRCT_BIT_ADD_DONE 14
`define SRCT_BIT_ADD_OVF  15
`define SRCT_EV_ERR       4

`define SRCT_PORT_PRI     4'h1
`define SRCT_PORT_ADD     4'h2
`define SRCT_MON_MAX      4'h3
`define SRCT_ORDER_MAX    4'h3
`define SRCT_N_MAX        16'h0100
`define SRCT_MSG_MAX      9'h100
`define SRCT_CR           8'h0d
`define SRCT_LF           8'h0a

`define SRCT_CFG_RST      32'h0000_0000
`define SRCT_NBYTES_RST   16'h0000
`define SRCT_MASK_RST     5'h00

`endif

// [srct_pkg.sv]
// Types shared by the receive completion tracker
package srct_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } srct_rx_byte_type;

  typedef struct packed {
    logic [7:0] count_target;
    logic [7:0] end_code;
    logic [7:0] start_code;
    logic [3:0] rsvd;
    logic       end_crlf;
    logic       end_en;
    logic       start_en;
    logic       no_proto;
  } srct_port_cfg_type;

  typedef struct packed {
    logic [3:0] rsvd;
    logic [3:0] port;
    logic [3:0] monitor;
    logic [3:0] order;
  } srct_ctrl_type;

  typedef enum logic [1:0] {CMD_IDLE, CMD_COPY, CMD_DONE} srct_cmd_state_type;

endpackage

// [srct_port_tracker.sv]
// One port: byte counter, completion and overflow flags, message buffer
`timescale 1ns/1ps
`default_nettype none
`include "srct_defs.svh"

module srct_port_tracker (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_n_i,
  input  wire srct_pkg::srct_port_cfg_type cfg_i,
  input  wire srct_pkg::srct_rx_byte_type  rx_i,
  input  wire logic                       read_clear_i,
  input  wire logic                       zero_clear_i,
  input  wire logic                       restart_i,
  input  wire logic [7:0]                 rd_addr_i,
  output logic [7:0]                      rd_data_o,
  output logic [8:0]                      count_o,
  output logic                            done_o,
  output logic                            overflow_o
);
  import srct_pkg::*;

  logic [7:0] mem [0:255];
  logic       started;
  logic       cr_pend;
  logic [8:0] next_count;
  logic       next_done;
  logic       next_overflow;
  logic       next_started;
  logic       next_cr_pend;
  logic       wr_en;
  logic [7:0] wr_addr;

  wire       clr    = read_clear_i | zero_clear_i | restart_i;
  wire       take   = rx_i.valid & cfg_i.no_proto;
  wire [8:0] tgt    = (cfg_i.count_target == 8'h00) ? `SRCT_MSG_MAX
                                                    : {1'b0, cfg_i.count_target};
  wire       is_cr  = cfg_i.end_en & cfg_i.end_crlf & (rx_i.data == `SRCT_CR);
  wire       is_end = cfg_i.end_en & (cfg_i.end_crlf ? (cr_pend & (rx_i.data == `SRCT_LF))
                                                     : (rx_i.data == cfg_i.end_code));

  // A clear and a byte in one cycle: the byte opens the fresh message
  always_comb begin
    next_count    = clr ? 9'h000 : count_o;
    next_done     = clr ? 1'b0 : done_o;
    next_overflow = zero_clear_i ? 1'b0 : overflow_o;
    next_started  = clr ? 1'b0 : started;
    next_cr_pend  = clr ? 1'b0 : cr_pend;
    wr_en         = 1'b0;
    wr_addr       = next_count[7:0];
    if (take) begin
      if (next_done) begin
        next_overflow = 1'b1;
      end else if (cfg_i.start_en & ~next_started) begin
        next_started = (rx_i.data == cfg_i.start_code);
      end else if (is_end) begin
        next_done = 1'b1;
      end else begin
        wr_en        = 1'b1;
        wr_addr      = next_count[7:0] + {7'h00, next_cr_pend};
        next_count   = next_count + {8'h00, next_cr_pend} + {8'h00, ~is_cr};
        next_cr_pend = is_cr;
        if (cfg_i.end_en ? (next_count >= `SRCT_MSG_MAX) : (next_count >= tgt)) begin
          next_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o    <= 9'h000;
      done_o     <= 1'b0;
      overflow_o <= 1'b0;
      started    <= 1'b0;
      cr_pend    <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      count_o    <= next_count;
      done_o     <= next_done;
      overflow_o <= next_overflow;
      started    <= next_started;
      cr_pend    <= next_cr_pend;
      rd_data_o  <= mem[rd_addr_i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_en) begin
      mem[wr_addr] <= rx_i.data;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_done_at_target: assert property ($rose(done_o) && !cfg_i.end_en |-> count_o == tgt)
    else $error("done rose away from target count");
  chk_count_range: assert property (count_o <= `SRCT_MSG_MAX)
    else $error("byte counter above 256");
  chk_ovf_after_done: assert property (done_o && take && !clr |=> overflow_o)
    else $error("late byte did not raise overflow");
  chk_hold_message: assert property (done_o && take && !clr |=> $stable(count_o) && done_o)
    else $error("late byte altered the message");
  chk_restart_clear: assert property (restart_i && !take |=> !done_o && count_o == 9'h000)
    else $error("restart did not clear");
  chk_zero_read: assert property (zero_clear_i && !take |=> !done_o && !overflow_o)
    else $error("zero-length read left flags set");
  cov_done: cover property ($rose(done_o));
  cov_ovf: cover property ($rose(overflow_o));

endmodule
`default_nettype wire

// [srct_byte_source.sv]
// Far-side serial device model: sends framing-free bytes to one receive port
`timescale 1ns/1ps
`default_nettype none

module srct_byte_source (
  input  wire logic                      sys_clk_i,
  output var  srct_pkg::srct_rx_byte_type rx_o
);
  import srct_pkg::*;

  initial rx_o = '0;

  // One-cycle valid pulse per byte; data lines carry junk between bytes
  task automatic send(input logic [7:0] b, input int gap);
    begin
      @(posedge sys_clk_i);
      rx_o <= '{valid: 1'b1, data: b};
      @(posedge sys_clk_i);
      rx_o <= '{valid: 1'b0, data: ~b};
      repeat (gap) @(posedge sys_clk_i);
    end
  endtask
endmodule

`default_nettype wire

// [srct_top_test.sv]
// Self-checking bench for the receive completion tracker
`timescale 1ns/1ps
`default_nettype none
`include "srct_defs.svh"

module srct_top_test;
  import srct_pkg::*;

  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [11:0]       addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wdata = '0;
  logic [31:0]       readdata;
  logic              waitreq;
  logic              irq;
  srct_rx_byte_type  pri_rx;
  srct_rx_byte_type  add_rx;
  int                err_count = 0;
  int                total_checks = 0;
  logic [7:0]        pat [3] = '{8'ha1, 8'hb2, 8'hc3};
  logic [7:0]        frm [7] = '{8'h55, 8'h02, 8'h41, 8'h0d, 8'h42, 8'h0d, 8'h0a};
  logic [15:0]       bad [5] = '{16'h0000, 16'h0300, 16'h0140, 16'h0104, 16'h1100};
  localparam logic [31:0] FULL = 32'hffff_ffff;
  localparam logic [31:0] PD = 32'h1 << `SRCT_BIT_PRI_DONE;
  localparam logic [31:0] PO = 32'h1 << `SRCT_BIT_PRI_OVF;
  localparam logic [31:0] AD = 32'h1 << `SRCT_BIT_ADD_DONE;
  localparam logic [31:0] AO = 32'h1 << `SRCT_BIT_ADD_OVF;
  localparam logic [31:0] EV = 32'h1 << `SRCT_EV_ERR;

  always #50 sys_clk = ~sys_clk;

  srct_top u_srct_top (
    .sys_clk_i         (sys_clk),
    .reset_n_i         (reset_n),
    .avs_address_i     (addr),
    .avs_read_i        (rd),
    .avs_write_i       (wr),
    .avs_writedata_i   (wdata),
    .avs_byteenable_i  (4'hf),
    .avs_readdata_o    (readdata),
    .avs_waitrequest_o (waitreq),
    .primary_rx_i      (pri_rx),
    .addon_rx_i        (add_rx),
    .irq_o             (irq)
  );

  srct_byte_source u_pri (.sys_clk_i(sys_clk), .rx_o(pri_rx));
  srct_byte_source u_add (.sys_clk_i(sys_clk), .rx_o(add_rx));

  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do begin
        @(posedge sys_clk);
        n++;
      end while (waitreq !== 1'b0 && n < 3000);
      if (waitreq !== 1'b0) begin
        err_count++;
        $display("MISMATCH bus_wait expected %h seen %h", 1'b0, waitreq);
      end
      q = readdata;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input string nm, input logic [11:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q & m, exp);
  endtask

  task automatic cmd(input logic [15:0] ctl, input logic [15:0] n, input logic [31:0] exp);
    wreg(`SRCT_OFS_NBYTES, {16'h0, n});
    wreg(`SRCT_OFS_CMD, {16'h0, ctl});
    rreg("result", `SRCT_OFS_RESULT, exp, 32'h01ff_0001);
  endtask

  task final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rreg("status", `SRCT_OFS_STATUS, 32'h0, FULL);
    rreg("pri count", `SRCT_OFS_PRI_CNT, 32'h0, FULL);
    rreg("add count", `SRCT_OFS_ADD_CNT, 32'h0, FULL);
    rreg("unmapped", 12'h100, 32'h0, FULL);
    wreg(`SRCT_OFS_STATUS, FULL);
    rreg("status ro", `SRCT_OFS_STATUS, 32'h0, FULL);
    // Unconfigured port refused; error event drives irq only when unmasked
    cmd(16'h0200, 16'h0001, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wreg(`SRCT_OFS_MASK, EV);
    @(negedge sys_clk);
    check("irq", {31'h0, irq}, 32'h1);
    rreg("event", `SRCT_OFS_EVENT, EV, FULL);
    @(negedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Primary in count mode, three bytes per message
    wreg(`SRCT_OFS_PRI_CFG, 32'h0300_0001);
    foreach (bad[i]) cmd(bad[i], 16'h0001, 32'h1);
    cmd(16'h0100, 16'h0101, 32'h1);
    cmd(16'h0100, 16'h0100, 32'h0);
    for (int i = 0; i < 3; i++) u_pri.send(pat[i], i);
    rreg("status", `SRCT_OFS_STATUS, PD, FULL);
    rreg("pri count", `SRCT_OFS_PRI_CNT, 32'h3, FULL);
    u_pri.send(8'hd4, 0);
    rreg("status", `SRCT_OFS_STATUS, PD | PO, FULL);
    cmd(16'h0100, 16'h0003, 32'h0003_0000);
    for (int i = 0; i < 3; i++)
      rreg("dest", 12'h400 + 12'(4 * i), {24'h0, pat[i]}, 32'hff);
    rreg("status", `SRCT_OFS_STATUS, PO, FULL);
    rreg("pri count", `SRCT_OFS_PRI_CNT, 32'h0, FULL);
    cmd(16'h0100, 16'h0000, 32'h0);
    rreg("status", `SRCT_OFS_STATUS, 32'h0, FULL);
    // Add-on port with a terminator byte
    wreg(`SRCT_OFS_ADD_CFG, 32'h000d_0005);
    u_add.send(8'h11, 0);
    u_add.send(8'h22, 3);
    u_add.send(8'h0d, 0);
    rreg("status", `SRCT_OFS_STATUS, AD, FULL);
    rreg("add count", `SRCT_OFS_ADD_CNT, 32'h2, FULL);
    u_add.send(8'h33, 0);
    rreg("status", `SRCT_OFS_STATUS, AD | AO, FULL);
    wreg(`SRCT_OFS_RESTART, 32'h2);
    rreg("status", `SRCT_OFS_STATUS, AO, FULL);
    rreg("add count", `SRCT_OFS_ADD_CNT, 32'h0, FULL);
    cmd(16'h0200, 16'h0000, 32'h0);
    rreg("status", `SRCT_OFS_STATUS, 32'h0, FULL);
    for (int i = 0; i < 256; i++) u_add.send(8'h20, 0);
    rreg("status", `SRCT_OFS_STATUS, AD, FULL);
    rreg("add count", `SRCT_OFS_ADD_CNT, 32'h100, FULL);
    u_add.send(8'h20, 0);
    rreg("status", `SRCT_OFS_STATUS, AD | AO, FULL);
    // Primary restart
    for (int i = 0; i < 3; i++) u_pri.send(pat[i], 0);
    rreg("status", `SRCT_OFS_STATUS, PD, 32'h00c0);
    wreg(`SRCT_OFS_RESTART, 32'h1);
    rreg("status", `SRCT_OFS_STATUS, 32'h0, 32'h00c0);
    rreg("pri count", `SRCT_OFS_PRI_CNT, 32'h0, FULL);
    // Primary with start code and CR+LF end; a CR before a non-LF byte is data
    wreg(`SRCT_OFS_PRI_CFG, 32'h0000_020f);
    foreach (frm[i]) u_pri.send(frm[i], 0);
    rreg("status", `SRCT_OFS_STATUS, PD, 32'h00c0);
    rreg("pri count", `SRCT_OFS_PRI_CNT, 32'h3, FULL);
    cmd(16'h0100, 16'h0003, 32'h0003_0000);
    for (int i = 0; i < 3; i++)
      rreg("dest", 12'h400 + 12'(4 * i), {24'h0, frm[i + 2]}, 32'hff);
    final_report();
  end
endmodule

`default_nettype wire
